/* File: logic/wss_top.v */
// Wakeup startup sequencer top: timeline, flags and alert pin.
`include "wss_defines.vh"
`default_nettype none
module wss_top #(
    parameter TICK_CYC = `WSS_TICK_CYC
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire        pslverr,
    output wire [31:0] prdata,
    input  wire        second_thermistor_pin,
    input  wire        load_detect_pin,
    input  wire        shutdown_req,
    output reg         aux_regulator_output,
    output reg         init_started_flag,
    output reg         init_complete_flag,
    output reg         conversion_scan_flag,
    output reg         full_scan_flag,
    output reg         fets_enabled,
    output reg         normal_mode,
    output wire        alert_out,
    output wire        alert_oe,
    output wire        irq
);
    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    localparam ST_SHUT   = 3'd0;
    localparam ST_REG    = 3'd1;
    localparam ST_INIT   = 3'd2;
    localparam ST_COMP   = 3'd3;
    localparam ST_FULL   = 3'd4;
    localparam ST_FET    = 3'd5;
    localparam ST_NORMAL = 3'd6;

    wire [3:0]  ctrl_reg;
    wire        fast_conversion_select = ctrl_reg[0];
    wire        autonomous_fet_control = ctrl_reg[1];
    wire        reg_auto               = ctrl_reg[2];
    wire        alert_present          = ctrl_reg[3];
    reg  [2:0]  state_reg;
    reg  [2:0]  state_next;
    reg  [15:0] ms_reg;
    reg  [15:0] eval_reg;
    reg  [4:0]  ev;
    wire        tick;
    wire        wake = ~second_thermistor_pin | load_detect_pin;
    wire        alarm;

    function [15:0] pick;
        input       fast;
        input [15:0] slow_ms;
        input [15:0] fast_ms;
        begin
            pick = fast ? fast_ms : slow_ms;
        end
    endfunction

    wire [15:0] t_comp = pick(fast_conversion_select, `WSS_T_COMP_SLOW_MS,
                              `WSS_T_COMP_FAST_MS);
    wire [15:0] t_full = pick(fast_conversion_select, `WSS_T_FULL_SLOW_MS,
                              `WSS_T_FULL_FAST_MS);
    wire [15:0] t_fet  = pick(fast_conversion_select, `WSS_T_FET_SLOW_MS,
                              `WSS_T_FET_FAST_MS);

    wss_tick #(.TICK_CYC(TICK_CYC)) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (state_reg != ST_SHUT),
        .tick    (tick)
    );

    wss_apb u_apb (
        .pclk     (pclk),
        .presetn  (presetn),
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .paddr    (paddr),
        .pwdata   (pwdata),
        .pready   (pready),
        .pslverr  (pslverr),
        .prdata   (prdata),
        .events   (ev),
        .state    (state_reg),
        .fets_on  (fets_enabled),
        .ctrl_reg (ctrl_reg),
        .irq      (irq)
    );

    // ------------------------------------------------------------
    // Milestone sequence
    // ------------------------------------------------------------
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            ST_SHUT:   if (wake) state_next = ST_REG;
            ST_REG:    if (ms_reg >= `WSS_T_REG_MS) state_next = ST_INIT;
            ST_INIT:   if (ms_reg >= `WSS_T_INIT_MS) state_next = ST_COMP;
            ST_COMP:   if (ms_reg >= t_comp) state_next = ST_FULL;
            ST_FULL:   if (ms_reg >= t_full) state_next = ST_FET;
            ST_FET:    if (ms_reg >= t_fet) state_next = ST_NORMAL;
            ST_NORMAL: if (shutdown_req) state_next = ST_SHUT;
            default:   state_next = ST_SHUT;
        endcase
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg            <= ST_SHUT;
            ms_reg               <= 16'h0000;
            eval_reg             <= 16'h0000;
            ev                   <= 5'h00;
            aux_regulator_output <= 1'b0;
            init_started_flag    <= 1'b0;
            init_complete_flag   <= 1'b0;
            conversion_scan_flag <= 1'b0;
            full_scan_flag       <= 1'b0;
            fets_enabled         <= 1'b0;
            normal_mode          <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            ev        <= 5'h00;
            if (state_reg == ST_SHUT)
                ms_reg <= 16'h0000;
            else if (tick && ms_reg != 16'hFFFF)
                ms_reg <= ms_reg + 16'h0001;
            case (state_reg)
                ST_SHUT:
                begin
                    aux_regulator_output <= 1'b0;
                    init_started_flag    <= 1'b0;
                    init_complete_flag   <= 1'b0;
                    conversion_scan_flag <= 1'b0;
                    full_scan_flag       <= 1'b0;
                    fets_enabled         <= 1'b0;
                    normal_mode          <= 1'b0;
                end
                ST_REG:
                    if (state_next == ST_INIT)
                    begin
                        aux_regulator_output <= reg_auto;
                        ev[`WSS_EV_REG]      <= 1'b1;
                    end
                ST_INIT:
                    if (state_next == ST_COMP)
                    begin
                        init_started_flag <= 1'b1;
                        ev[`WSS_EV_INIT]  <= 1'b1;
                    end
                ST_COMP:
                    if (state_next == ST_FULL)
                    begin
                        init_complete_flag   <= 1'b1;
                        conversion_scan_flag <= 1'b1;
                        ev[`WSS_EV_COMP]     <= 1'b1;
                    end
                ST_FULL:
                    if (state_next == ST_FET)
                    begin
                        full_scan_flag   <= 1'b1;
                        ev[`WSS_EV_FULL] <= 1'b1;
                    end
                ST_FET:
                    if (state_next == ST_NORMAL)
                    begin
                        fets_enabled    <= autonomous_fet_control;
                        normal_mode     <= 1'b1;
                        eval_reg        <= 16'h0000;
                        ev[`WSS_EV_FET] <= autonomous_fet_control;
                    end
                ST_NORMAL:
                    if (tick)
                    begin
                        if (eval_reg == `WSS_T_EVAL_MS - 16'h0001)
                        begin
                            eval_reg     <= 16'h0000;
                            fets_enabled <= autonomous_fet_control;
                        end
                        else
                            eval_reg <= eval_reg + 16'h0001;
                    end
                default:
                    normal_mode <= 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Alert pin, open drain
    // ------------------------------------------------------------
    assign alarm     = alert_present & (init_started_flag | init_complete_flag
                       | conversion_scan_flag | full_scan_flag);
    assign alert_out = 1'b0;
    assign alert_oe  = alarm;
endmodule // wss_top
`default_nettype wire

/* File: logic/wss_defines.vh */
// Constants for the wakeup startup sequencer.
// Operation
// - Leaving shutdown, step through fixed milestones, then enter normal mode.
// - Second thermistor pin low or load detect pin high is wakeup.
// - If enabled, power the auxiliary regulator 20 ms after wakeup.
// - Always raise init started flag 23 ms after wakeup.
// - Init complete and scan flags at 88 ms, or 58 ms fast.
// - Full scan flag at 221 ms, or 129 ms with fast conversion.
// - Autonomous FET enable at 282 ms, or 284 ms fast.
// - In normal mode, FET decision is re-evaluated every 250 ms only.
// - Alert pin is pulled low while alarm active, else released.
`ifndef WSS_DEFINES_VH
`define WSS_DEFINES_VH
`define WSS_CLK_HZ          20000000
`define WSS_TICK_US         1000
`define WSS_TICK_CYC        ((`WSS_CLK_HZ / 1000000) * `WSS_TICK_US)
`define WSS_T_REG_MS        16'h0014
`define WSS_T_INIT_MS       16'h0017
`define WSS_T_COMP_SLOW_MS  16'h0058
`define WSS_T_COMP_FAST_MS  16'h003A
`define WSS_T_FULL_SLOW_MS  16'h00DD
`define WSS_T_FULL_FAST_MS  16'h0081
`define WSS_T_FET_SLOW_MS   16'h011A
`define WSS_T_FET_FAST_MS   16'h011C
`define WSS_T_EVAL_MS       16'h00FA
`define WSS_ADDR_CTRL       12'h000
`define WSS_ADDR_STAT       12'h004
`define WSS_ADDR_MASK       12'h008
`define WSS_ADDR_STATE      12'h00C
`define WSS_CTRL_RST        32'h0000000F
`define WSS_EV_REG          0
`define WSS_EV_INIT         1
`define WSS_EV_COMP         2
`define WSS_EV_FULL         3
`define WSS_EV_FET          4
`define WSS_NEV             5
`endif

/* File: logic/wss_tick.v */
// Reference tick generator for the startup sequencer.
`include "wss_defines.vh"
`default_nettype none
module wss_tick #(
    parameter TICK_CYC = `WSS_TICK_CYC
) (
    input  wire pclk,
    input  wire presetn,
    input  wire run,
    output reg  tick
);
    reg [31:0] cnt_reg;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_reg <= 32'h00000000;
            tick    <= 1'b0;
        end
        else if (!run)
        begin
            cnt_reg <= 32'h00000000;
            tick    <= 1'b0;
        end
        else if (cnt_reg == TICK_CYC - 1)
        begin
            cnt_reg <= 32'h00000000;
            tick    <= 1'b1;
        end
        else
        begin
            cnt_reg <= cnt_reg + 32'h00000001;
            tick    <= 1'b0;
        end
    end
endmodule // wss_tick
`default_nettype wire

/* File: logic/wss_apb.v */
// APB register file for the startup sequencer.
`include "wss_defines.vh"
`default_nettype none
module wss_apb (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire        pslverr,
    output reg  [31:0] prdata,
    input  wire [4:0]  events,
    input  wire [2:0]  state,
    input  wire        fets_on,
    output reg  [3:0]  ctrl_reg,
    output wire        irq
);
    reg [4:0] stat_reg;
    reg [4:0] mask_reg;
    wire wr = psel & penable & pwrite;
    wire setup_rd = psel & ~penable & ~pwrite;
    wire hit = (paddr == `WSS_ADDR_CTRL) | (paddr == `WSS_ADDR_STAT) |
               (paddr == `WSS_ADDR_MASK) | (paddr == `WSS_ADDR_STATE);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign irq     = |(stat_reg & mask_reg);
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg <= 4'hF;
            mask_reg <= 5'h00;
            stat_reg <= 5'h00;
            prdata   <= 32'h00000000;
        end
        else
        begin
            if (wr && paddr == `WSS_ADDR_CTRL)
                ctrl_reg <= pwdata[3:0];
            if (wr && paddr == `WSS_ADDR_MASK)
                mask_reg <= pwdata[4:0];
            if (wr && paddr == `WSS_ADDR_STAT)
                stat_reg <= (stat_reg & ~pwdata[4:0]) | events;
            else
                stat_reg <= stat_reg | events;
            if (setup_rd)
            begin
                case (paddr)
                    `WSS_ADDR_CTRL:  prdata <= {28'h0000000, ctrl_reg};
                    `WSS_ADDR_STAT:  prdata <= {27'h0000000, stat_reg};
                    `WSS_ADDR_MASK:  prdata <= {27'h0000000, mask_reg};
                    `WSS_ADDR_STATE: prdata <= {28'h0000000, fets_on, state};
                    default:         prdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // wss_apb
`default_nettype wire

/* File: dv/wss_host_model.sv */
// Host side model of the open-drain alert line.
`default_nettype none
module wss_host_model (
    input  wire logic alert_out,
    input  wire logic alert_oe,
    output wire logic alert_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // The pull-up holds the line high whenever the device lets go.
    assign alert_n = alert_oe ? alert_out : 1'b1;
endmodule // wss_host_model
`default_nettype wire

/* File: dv/wss_top_checker.sv */
// Port checker for the wakeup startup sequencer.
`default_nettype none
module wss_top_checker #(
    parameter int TICK_CYC = 10
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        aux_regulator_output,
    input wire logic        init_started_flag,
    input wire logic        init_complete_flag,
    input wire logic        conversion_scan_flag,
    input wire logic        full_scan_flag,
    input wire logic        fets_enabled,
    input wire logic        alert_out,
    input wire logic        alert_oe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    int gap_reg;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            gap_reg <= 0;
        else if ($rose(aux_regulator_output))
            gap_reg <= 1;
        else if (gap_reg != 0)
            gap_reg <= gap_reg + 1;
    sequence s_access;
        psel && penable;
    endsequence
    apb_zero_wait_a: assert property (
        s_access |-> pready)
        else $error("access phase without ready");
    unmapped_err_a: assert property (
        s_access ##0 paddr > 12'h00C |-> pslverr)
        else $error("unmapped access without error");
    err_in_access_a: assert property (
        pslverr |-> psel && penable)
        else $error("error outside access phase");
    init_after_reg_a: assert property (
        $rose(init_started_flag) |-> aux_regulator_output)
        else $error("init flag before regulator");
    init_gap_a: assert property (
        $rose(init_started_flag) |->
        gap_reg >= 3 * TICK_CYC - 2 && gap_reg <= 3 * TICK_CYC + 2)
        else $error("init flag not three ticks after regulator");
    scan_with_comp_a: assert property (
        $rose(init_complete_flag) |-> conversion_scan_flag)
        else $error("scan flag missing with init complete");
    full_after_comp_a: assert property (
        $rose(full_scan_flag) |-> init_complete_flag)
        else $error("full scan before init complete");
    fet_after_full_a: assert property (
        $rose(fets_enabled) |-> full_scan_flag && init_started_flag)
        else $error("fets enabled too early");
    alert_drive_low_a: assert property (
        alert_oe |-> !alert_out)
        else $error("alert driven high");
endmodule // wss_top_checker
bind wss_top wss_top_checker #(.TICK_CYC(TICK_CYC)) chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .aux_regulator_output(aux_regulator_output),
    .init_started_flag(init_started_flag),
    .init_complete_flag(init_complete_flag),
    .conversion_scan_flag(conversion_scan_flag),
    .full_scan_flag(full_scan_flag), .fets_enabled(fets_enabled),
    .alert_out(alert_out), .alert_oe(alert_oe));
`default_nettype wire

/* File: dv/wss_top_tb_top.sv */
// Self-checking bench for the wakeup startup sequencer.
`default_nettype none
module wss_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TC = 10;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic        therm_pin = 1'b1;
    logic        load_pin = 1'b0;
    logic        shut_req = 1'b0;
    wire         pready, pslverr, irq, alert_out, alert_oe, alert_n;
    wire         scan_f, normal_f;
    wire  [31:0] prdata;
    wire  [4:0]  ms;
    int          mismatches = 0;
    int          checks_done = 0;
    int          cyc = 0;
    logic [31:0] rd;
    logic        err;
    int          t_exp [2][5] = '{'{20, 23, 88, 221, 282},
                                  '{20, 23, 58, 129, 284}};
    always #25 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;
    wss_top #(.TICK_CYC(TC)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata),
        .second_thermistor_pin(therm_pin), .load_detect_pin(load_pin),
        .shutdown_req(shut_req), .aux_regulator_output(ms[0]),
        .init_started_flag(ms[1]), .init_complete_flag(ms[2]),
        .conversion_scan_flag(scan_f), .full_scan_flag(ms[3]),
        .fets_enabled(ms[4]), .normal_mode(normal_f),
        .alert_out(alert_out), .alert_oe(alert_oe), .irq(irq));
    wss_host_model host (.alert_out(alert_out), .alert_oe(alert_oe),
        .alert_n(alert_n));
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            chk("pready", 1, 0);
        if (n >= 20)
            test_done();
        err = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic run_row(int r);
        int first [5];
        int c;
        int on_cyc;
        first = '{default: -1};
        if (r == 0)
            therm_pin <= 1'b0;
        else
            load_pin <= 1'b1;
        c = 0;
        while (ms[4] !== 1'b1 && c < 300 * TC)
        begin
            @(posedge pclk);
            @(negedge pclk);
            c++;
            for (int i = 0; i < 5; i++)
                if (first[i] < 0 && ms[i] === 1'b1)
                    first[i] = c;
        end
        on_cyc = cyc;
        for (int i = 0; i < 5; i++)
            chk("milestone", t_exp[r][i] * TC,
                (first[i] - t_exp[r][i] * TC) inside {[-1:3]} ?
                t_exp[r][i] * TC : first[i]);
        if (ms[4] !== 1'b1)
            test_done();
        chk("scan flag", 1, scan_f);
        chk("normal mode", 1, normal_f);
        chk("alert pin", r, alert_n);
        @(posedge pclk);
        if (r == 0)
        begin
            apb(1, 12'h000, 32'h0000000C);
            @(negedge pclk);
            chk("fet held", 1, ms[4]);
            c = 0;
            while (ms[4] !== 1'b0 && c < 300 * TC)
            begin
                @(negedge pclk);
                c++;
            end
            chk("fet hold", 250 * TC,
                (cyc - on_cyc - 250 * TC) inside {[-1:1]} ?
                250 * TC : cyc - on_cyc);
            if (ms[4] !== 1'b0)
                test_done();
            @(posedge pclk);
        end
        therm_pin <= 1'b1;
        load_pin <= 1'b0;
        shut_req <= 1'b1;
        c = 0;
        while (normal_f !== 1'b0 && c < 50)
        begin
            @(negedge pclk);
            c++;
        end
        @(posedge pclk);
        shut_req <= 1'b0;
        chk("normal cleared", 0, normal_f);
        if (normal_f !== 1'b0)
            test_done();
        repeat (3) @(posedge pclk);
        chk("flags cleared", 0, {normal_f, scan_f, ms});
        $display("row %0d done", r);
    endtask
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("alert idle", 1, alert_n);
        apb(0, 12'h000, 0);
        chk("ctrl reset", 32'h0000000F, rd);
        for (int r = 0; r < 2; r++)
        begin
            apb(1, 12'h000, r ? 32'h00000007 : 32'h0000000E);
            run_row(r);
        end
        apb(0, 12'h004, 0);
        chk("status sticky", 32'h0000001F, rd);
        chk("irq masked", 0, irq);
        apb(1, 12'h008, 32'h00000001);
        chk("irq raised", 1, irq);
        apb(1, 12'h004, 32'h0000001F);
        chk("irq cleared", 0, irq);
        apb(0, 12'h004, 0);
        chk("status cleared", 0, rd);
        apb(0, 12'h010, 0);
        chk("unmapped error", 1, err);
        chk("unmapped data", 0, rd);
        apb(0, 12'h00C, 0);
        chk("state shutdown", 0, rd);
        $display("register test done");
        test_done();
    end
endmodule // wss_top_tb_top
`default_nettype wire
